// ==== rtl/loc_pkg.sv ====
// shared types and constants of the ladder output control engine
package loc_pkg;
	// ----------------------------------------------------------------
	// sizes and step counts
	// ----------------------------------------------------------------
	localparam int            ADDR_W    = 10;
	localparam int            DEV_W     = 8;
	localparam int            PROG_DEP  = 1024;
	localparam int            DEV_DEP   = 256;
	localparam int            MC_LVLS   = 8;
	localparam logic [10:0]   LAST_STEP = 11'h03FF;
	localparam logic [10:0]   STEP_ONE  = 11'h0001;
	localparam logic [10:0]   STEP_LONG = 11'h0003;
	localparam logic [9:0]    PC_RST    = 10'h000;
	localparam logic [7:0]    DEV_ONE   = 8'h01;

	// ----------------------------------------------------------------
	// opcodes and operand kinds
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP  = 4'h0,
		OP_SET  = 4'h1,
		OP_CLR  = 4'h2,
		OP_OUT  = 4'h3,
		OP_RISE = 4'h4,
		OP_FALL = 4'h5,
		OP_SFT  = 4'h6,
		OP_BIT_SHIFT_PULSED = 4'h7,
		OP_MCB  = 4'h8,
		OP_MCR  = 4'h9,
		OP_END  = 4'hF
	} loc_op_e;

	typedef enum logic [2:0] {
		K_BIT  = 3'h0, // plain output or internal relay
		K_SPEC = 3'h1, // special relay
		K_TMR  = 3'h2, // 100ms or 10ms timer
		K_RTMR = 3'h3, // retentive timer
		K_CNT  = 3'h4, // counter
		K_WORD = 3'h5  // data word
	} loc_kind_e;

	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_CHECK = 6'h02,
		S_RD    = 6'h04,
		S_WR    = 6'h08,
		S_WR2   = 6'h10,
		S_ERR   = 6'h20
	} loc_state_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		loc_op_e          op;
		loc_kind_e        kind;
		logic [DEV_W-1:0] idx;
		logic [2:0]       lvl;
		logic             cond; // operation result up to this instruction
	} loc_instr_s;

	typedef struct packed {
		logic             vld;
		logic [DEV_W-1:0] idx;
		logic             val;
	} loc_bit_wr_s;

	typedef struct packed {
		logic             vld;
		loc_kind_e        kind;
		logic [DEV_W-1:0] idx;
		logic             coil;
		logic             clr;  // clear count and contact
	} loc_tc_cmd_s;

	typedef struct packed {
		logic             vld;
		logic [DEV_W-1:0] idx;
	} loc_word_clr_s;
endpackage

// ==== rtl/loc_bit_mem.sv ====
// single-bit memory with one write port and two registered read ports
module loc_bit_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic          wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic               rdata_o,
	input  wire logic [AW-1:0] raddr2_i,
	output logic               rdata2_o
);
	logic mem_q [DEPTH];

	// ----------------------------------------------------------------
	// storage, cleared so every device starts off
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 1'b0;
			end
		end else if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	// read ports show the value before a same-cycle write
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o  <= 1'b0;
			rdata2_o <= 1'b0;
		end else begin
			rdata_o  <= mem_q[raddr_i];
			rdata2_o <= mem_q[raddr2_i];
		end
	end
endmodule // loc_bit_mem

// ==== rtl/loc_mc_stack.sv ====
// master control nesting flags, one open and one active bit per level
module loc_mc_stack (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       clear_i,
	input  wire logic       open_i,
	input  wire logic       close_i,
	input  wire logic [2:0] lvl_i,
	input  wire logic       cond_i,
	output logic            en_o
);
	logic [loc_pkg::MC_LVLS-1:0] open_q;
	logic [loc_pkg::MC_LVLS-1:0] act_q;

	// ----------------------------------------------------------------
	// per level flags
	// ----------------------------------------------------------------
	for (genvar g = 0; g < loc_pkg::MC_LVLS; g++) begin : g_lvl
		always_ff @(posedge clock_i) begin
			if (rst_i || clear_i) begin
				open_q[g] <= 1'b0;
				act_q[g]  <= 1'b0;
			end else if (close_i && (lvl_i <= 3'(g))) begin
				open_q[g] <= 1'b0; // one low release ends all above [RQ20]
				act_q[g]  <= 1'b0;
			end else if (open_i && (lvl_i == 3'(g))) begin
				open_q[g] <= 1'b1; // ascending order assumed [RQ19]
				act_q[g]  <= cond_i;
			end
		end
	end

	// enabled only while every open level is active [RQ27]
	assign en_o = &(act_q | ~open_q);
endmodule // loc_mc_stack

// ==== rtl/loc_ladder_exec.sv ====
// scan engine for set, clear, edge pulse, shift, master control and end
// How it works
// RQ1: set and clear evaluated every scan
// RQ2: special set, clear of word: three steps
// RQ3: rise pulse drives target on one scan
// RQ4: fall pulse drives target on one scan
// RQ5: one pulse instruction per target per scan
// RQ6: no pulse from stop to run transition
// RQ7: shift copies lower device, then clears it
// RQ8: program sets first device of shift chain
// RQ9: shifts ordered from high to low device
// RQ10: master control on runs range normally
// RQ11: master control off still scans range
// RQ12: gated plain timers cleared, coil off
// RQ13: gated retentive timers, counters: coil off
// RQ14: gated coils off, latched devices hold
// RQ15: master control begin drives operand coil
// RQ16: operand device used nowhere else
// RQ17: same level reusable with other operand
// RQ18: no contact right before release
// RQ19: eight levels, open up, close down
// RQ20: lowest release closes all open levels
// RQ21: end finishes scan, restarts at step 0
// RQ22: end only at program end
// RQ23: missing end flags error, no run
// RQ24: clear zeroes timers, counters, bits, words
// RQ25: set device stays on until cleared
// RQ26: previous condition kept per pulse instruction
// RQ27: per level active flags gate the range
module loc_ladder_exec (
	input  wire logic                          clock_i,
	input  wire logic                          rst_i,
	input  wire logic                          run_i,
	input  wire loc_pkg::loc_instr_s           instr_i,
	input  wire logic [loc_pkg::DEV_W-1:0]     mon_addr_i,
	output logic [loc_pkg::ADDR_W-1:0]         pc_o,
	output loc_pkg::loc_bit_wr_s               bit_wr_o,
	output loc_pkg::loc_tc_cmd_s               tc_cmd_o,
	output loc_pkg::loc_word_clr_s             word_clr_o,
	output logic                               mon_bit_o,
	output logic                               scan_end_o,
	output logic                               running_o,
	output logic                               op_err_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	loc_pkg::loc_state_e          state_q;
	logic [loc_pkg::ADDR_W-1:0]   pc_q;
	logic                         first_q;
	logic [10:0]                  pc_sum;
	logic                         long_step;
	logic                         over;
	logic                         en;
	logic                         act;
	logic                         bit_rd;
	logic                         prev;
	logic                         rise;
	logic                         fall;
	logic                         is_bit;
	logic                         shift_go;
	logic                         bit_we;
	logic [loc_pkg::DEV_W-1:0]    bit_wa;
	logic                         bit_wd;
	logic [loc_pkg::DEV_W-1:0]    bit_ra;
	logic                         edge_we;
	logic                         mc_open;
	logic                         mc_close;
	logic                         mc_clear;
	loc_pkg::loc_tc_cmd_s         tc_d;
	loc_pkg::loc_word_clr_s       word_d;
	loc_pkg::loc_instr_s          ins;

	assign ins = instr_i;

	// ----------------------------------------------------------------
	// step arithmetic
	// ----------------------------------------------------------------
	// long forms take three steps so the scan walks past their operands
	assign long_step = ((ins.op == loc_pkg::OP_SET) && (ins.kind == loc_pkg::K_SPEC))
		|| ((ins.op == loc_pkg::OP_CLR) && (ins.kind != loc_pkg::K_BIT)); // [RQ2]
	assign pc_sum = {1'b0, pc_q} + (long_step ? loc_pkg::STEP_LONG : loc_pkg::STEP_ONE);
	assign over   = pc_sum > loc_pkg::LAST_STEP;

	// ----------------------------------------------------------------
	// condition decode
	// ----------------------------------------------------------------
	assign is_bit = (ins.kind == loc_pkg::K_BIT) || (ins.kind == loc_pkg::K_SPEC);
	assign act    = ins.cond & en;
	// first scan after run loads history only, so no false edge [RQ6]
	assign rise   = ins.cond & ~prev & ~first_q; // [RQ26]
	assign fall   = ~ins.cond & prev & ~first_q; // [RQ26]
	assign shift_go = (state_q == loc_pkg::S_WR) && en
		&& (((ins.op == loc_pkg::OP_SFT) && ins.cond)
		|| ((ins.op == loc_pkg::OP_BIT_SHIFT_PULSED) && rise));
	// shift reads the device one below its target
	assign bit_ra = ((ins.op == loc_pkg::OP_SFT) || (ins.op == loc_pkg::OP_BIT_SHIFT_PULSED))
		? ins.idx - loc_pkg::DEV_ONE : ins.idx; // [RQ7]

	// ----------------------------------------------------------------
	// execute decode, acts in the write phases; the nesting clear also acts while idle, checking or in error
	// ----------------------------------------------------------------
	always_comb begin
		bit_we   = 1'b0;
		bit_wa   = ins.idx;
		bit_wd   = 1'b0;
		edge_we  = 1'b0;
		mc_open  = 1'b0;
		mc_close = 1'b0;
		tc_d     = '0;
		word_d   = '0;
		tc_d.idx  = ins.idx;
		tc_d.kind = ins.kind;
		word_d.idx = ins.idx;
		if (state_q == loc_pkg::S_WR2) begin
			bit_we = 1'b1; // lower device turned off after copy [RQ7]
			bit_wa = ins.idx - loc_pkg::DEV_ONE;
		end else if (state_q == loc_pkg::S_WR) begin
			unique case (ins.op)
				loc_pkg::OP_SET: begin
					// held device, untouched while gated or condition off [RQ1]
					bit_we = act && is_bit; // [RQ25] [RQ14]
					bit_wd = 1'b1;
				end
				loc_pkg::OP_CLR: begin
					bit_we     = act && is_bit; // [RQ1] [RQ24]
					tc_d.vld   = act && (ins.kind inside {loc_pkg::K_TMR,
						loc_pkg::K_RTMR, loc_pkg::K_CNT}); // [RQ24]
					tc_d.clr   = 1'b1;
					word_d.vld = act && (ins.kind == loc_pkg::K_WORD); // [RQ24]
				end
				loc_pkg::OP_OUT: begin
					// gated coils are forced off but still scanned [RQ11] [RQ14]
					bit_we   = is_bit;
					bit_wd   = act; // [RQ10]
					tc_d.vld = !is_bit && (ins.kind != loc_pkg::K_WORD);
					tc_d.coil = act; // [RQ13]
					// plain timers lose their count when off or gated
					tc_d.clr = !act && (ins.kind == loc_pkg::K_TMR); // [RQ12]
				end
				loc_pkg::OP_RISE: begin
					bit_we  = en;
					bit_wd  = rise; // [RQ3]
					edge_we = en; // one history bit per step [RQ5]
				end
				loc_pkg::OP_FALL: begin
					bit_we  = en;
					bit_wd  = fall; // [RQ4]
					edge_we = en;
				end
				loc_pkg::OP_SFT, loc_pkg::OP_BIT_SHIFT_PULSED: begin
					// high to low ordering keeps chained shifts one place [RQ9]
					bit_we  = shift_go;
					bit_wd  = bit_rd; // [RQ7] [RQ8]
					edge_we = en && (ins.op == loc_pkg::OP_BIT_SHIFT_PULSED);
				end
				loc_pkg::OP_MCB: begin
					mc_open = 1'b1; // level reuse is free, no check [RQ17]
					bit_we  = 1'b1;
					bit_wd  = act; // operand coil follows the gate [RQ15] [RQ16]
				end
				loc_pkg::OP_MCR: begin
					mc_close = 1'b1; // [RQ18] [RQ20]
				end
				default: begin
				end
			endcase
		end
	end

	assign mc_clear = (state_q != loc_pkg::S_WR) && (state_q != loc_pkg::S_WR2)
		&& (state_q != loc_pkg::S_RD)
		|| ((state_q == loc_pkg::S_WR) && (ins.op == loc_pkg::OP_END));

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= loc_pkg::S_IDLE;
			pc_q    <= loc_pkg::PC_RST;
			first_q <= 1'b0;
		end else if (!run_i) begin
			state_q <= loc_pkg::S_IDLE;
			pc_q    <= loc_pkg::PC_RST;
			first_q <= 1'b0;
		end else begin
			unique case (state_q)
				loc_pkg::S_IDLE: begin
					state_q <= loc_pkg::S_CHECK;
					pc_q    <= loc_pkg::PC_RST;
				end
				loc_pkg::S_CHECK: begin
					// dry walk: the program must hold an end before it runs
					if (ins.op == loc_pkg::OP_END) begin
						state_q <= loc_pkg::S_RD;
						pc_q    <= loc_pkg::PC_RST;
						first_q <= 1'b1;
					end else if (over) begin
						state_q <= loc_pkg::S_ERR; // [RQ23]
					end else begin
						pc_q <= pc_sum[loc_pkg::ADDR_W-1:0];
					end
				end
				loc_pkg::S_RD: begin
					state_q <= loc_pkg::S_WR;
				end
				loc_pkg::S_WR: begin
					if (ins.op == loc_pkg::OP_END) begin
						// later steps are never reached [RQ22]
						state_q <= loc_pkg::S_RD;
						pc_q    <= loc_pkg::PC_RST; // [RQ21]
						first_q <= 1'b0;
					end else if (shift_go) begin
						state_q <= loc_pkg::S_WR2;
					end else begin
						state_q <= loc_pkg::S_RD;
						pc_q    <= pc_sum[loc_pkg::ADDR_W-1:0];
					end
				end
				loc_pkg::S_WR2: begin
					state_q <= loc_pkg::S_RD;
					pc_q    <= pc_sum[loc_pkg::ADDR_W-1:0];
				end
				loc_pkg::S_ERR: begin
					state_q <= loc_pkg::S_ERR; // held until run drops [RQ23]
				end
				default: begin
					state_q <= loc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bit_wr_o   <= '0;
			tc_cmd_o   <= '0;
			word_clr_o <= '0;
		end else begin
			bit_wr_o.vld <= bit_we;
			bit_wr_o.idx <= bit_wa;
			bit_wr_o.val <= bit_wd;
			tc_cmd_o     <= tc_d;
			word_clr_o   <= word_d;
		end
	end

	// status flags
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scan_end_o <= 1'b0;
			running_o  <= 1'b0;
			op_err_o   <= 1'b0;
		end else begin
			scan_end_o <= (state_q == loc_pkg::S_WR) && (ins.op == loc_pkg::OP_END);
			running_o  <= run_i && ((state_q == loc_pkg::S_RD)
				|| (state_q == loc_pkg::S_WR) || (state_q == loc_pkg::S_WR2));
			op_err_o   <= run_i && (state_q == loc_pkg::S_ERR);
		end
	end

	assign pc_o = pc_q;

	// ----------------------------------------------------------------
	// device bits, step history and nesting
	// ----------------------------------------------------------------
	loc_bit_mem #(
		.DEPTH (loc_pkg::DEV_DEP),
		.AW    (loc_pkg::DEV_W)
	) u_dev (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.we_i     (bit_we),
		.waddr_i  (bit_wa),
		.wdata_i  (bit_wd),
		.raddr_i  (bit_ra),
		.rdata_o  (bit_rd),
		.raddr2_i (mon_addr_i),
		.rdata2_o (mon_bit_o)
	);

	// history kept per step, so each pulse instruction has its own bit
	loc_bit_mem #(
		.DEPTH (loc_pkg::PROG_DEP),
		.AW    (loc_pkg::ADDR_W)
	) u_hist (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.we_i     (edge_we),
		.waddr_i  (pc_q),
		.wdata_i  (ins.cond), // [RQ26]
		.raddr_i  (pc_q),
		.rdata_o  (prev),
		.raddr2_i (pc_q),
		.rdata2_o ()
	);

	loc_mc_stack u_mc (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.clear_i (mc_clear),
		.open_i  (mc_open),
		.close_i (mc_close),
		.lvl_i   (ins.lvl),
		.cond_i  (act),
		.en_o    (en)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	logic wr_ph;
	assign wr_ph = run_i && (state_q == loc_pkg::S_WR);

	AST_END_RESTART: assert property ( // [RQ21]
		wr_ph && (ins.op == loc_pkg::OP_END) |=> (pc_q == 10'h000) && scan_end_o)
		else $error("end did not restart at step zero");

	AST_LONG_STEP: assert property ( // [RQ2]
		wr_ph && long_step && !shift_go |=> pc_q == $past(pc_q) + 10'h003)
		else $error("long form did not advance three steps");

	AST_RISE_PULSE: assert property ( // [RQ3]
		wr_ph && (ins.op == loc_pkg::OP_RISE) && en
		|=> bit_wr_o.vld && (bit_wr_o.val == ($past(ins.cond) && !$past(prev)
		&& !$past(first_q))))
		else $error("rise pulse value wrong");

	AST_FALL_PULSE: assert property ( // [RQ4]
		wr_ph && (ins.op == loc_pkg::OP_FALL) && en
		|=> bit_wr_o.val == (!$past(ins.cond) && $past(prev) && !$past(first_q)))
		else $error("fall pulse value wrong");

	AST_FIRST_QUIET: assert property ( // [RQ6]
		wr_ph && first_q && ((ins.op == loc_pkg::OP_RISE) || (ins.op == loc_pkg::OP_FALL))
		|=> !bit_wr_o.val)
		else $error("pulse on first scan after run");

	AST_SHIFT_CLEAR: assert property ( // [RQ7]
		shift_go && run_i |=> (state_q == loc_pkg::S_WR2) ##1
		(bit_wr_o.vld && !bit_wr_o.val && (bit_wr_o.idx == $past(ins.idx, 2) - 8'h01)))
		else $error("shift did not clear lower device");

	AST_GATED_COIL: assert property ( // [RQ14]
		wr_ph && !en && (ins.op == loc_pkg::OP_OUT) && is_bit
		|=> bit_wr_o.vld && !bit_wr_o.val)
		else $error("gated coil not forced off");

	AST_GATED_TMR: assert property ( // [RQ12]
		wr_ph && !en && (ins.op == loc_pkg::OP_OUT) && (ins.kind == loc_pkg::K_TMR)
		|=> tc_cmd_o.vld && tc_cmd_o.clr && !tc_cmd_o.coil)
		else $error("gated timer not cleared");

	AST_SET_HOLD: assert property ( // [RQ25]
		wr_ph && (ins.op == loc_pkg::OP_SET) && !act |=> !bit_wr_o.vld)
		else $error("set wrote while condition off");

	AST_NO_END: assert property ( // [RQ23]
		run_i && (state_q == loc_pkg::S_CHECK) && (ins.op != loc_pkg::OP_END) && over
		##1 run_i |-> !op_err_o ##1 op_err_o)
		else $error("missing end not flagged");
endmodule // loc_ladder_exec

// ==== testbench/tb.sv ====
// self-checking bench for the ladder output control engine
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
		$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                          clock_i    = 1'b0;
	logic                          rst_i      = 1'b1;
	logic                          run_i      = 1'b0;
	logic [loc_pkg::DEV_W-1:0]     mon_addr_i = '0;
	loc_pkg::loc_instr_s           instr_i;
	logic [loc_pkg::ADDR_W-1:0]    pc_o;
	loc_pkg::loc_bit_wr_s          bit_wr_o;
	loc_pkg::loc_tc_cmd_s          tc_cmd_o;
	loc_pkg::loc_word_clr_s        word_clr_o;
	logic                          mon_bit_o;
	logic                          scan_end_o;
	logic                          running_o;
	logic                          op_err_o;
	loc_pkg::loc_instr_s           prog [0:1023];
	logic [255:0]                  dev, hit, wclr, tc_coil, tc_clr;
	logic [1023:0]                 visited;
	int                            err_count       = 0;
	int                            samples_checked = 0;
	int                            scan_len;
	int                            len_a;

	always #2 clock_i = ~clock_i;

	// program store answers combinationally at the step the engine points to
	assign instr_i = prog[pc_o];

	loc_ladder_exec u_dut (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.run_i      (run_i),
		.instr_i    (instr_i),
		.mon_addr_i (mon_addr_i),
		.pc_o       (pc_o),
		.bit_wr_o   (bit_wr_o),
		.tc_cmd_o   (tc_cmd_o),
		.word_clr_o (word_clr_o),
		.mon_bit_o  (mon_bit_o),
		.scan_end_o (scan_end_o),
		.running_o  (running_o),
		.op_err_o   (op_err_o)
	); // loc_ladder_exec

	// shadow of the device bits and commands, rebuilt only from the outputs
	always @(posedge clock_i) begin
		visited[pc_o] <= 1'b1;
		if (rst_i) begin
			dev     <= '0;
			wclr    <= '0;
			tc_coil <= '0;
			tc_clr  <= '0;
		end else begin
			if (bit_wr_o.vld) begin
				dev[bit_wr_o.idx] <= bit_wr_o.val;
				if (bit_wr_o.val) hit[bit_wr_o.idx] <= 1'b1;
			end
			if (tc_cmd_o.vld) begin
				tc_coil[tc_cmd_o.idx] <= tc_cmd_o.coil;
				tc_clr[tc_cmd_o.idx]  <= tc_cmd_o.clr;
			end
			if (word_clr_o.vld) wclr[word_clr_o.idx] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic put(input int a, input loc_pkg::loc_op_e op, input int idx, input logic c,
			input loc_pkg::loc_kind_e k = loc_pkg::K_BIT, input logic [2:0] lv = 3'h0);
		prog[a] = '{op, k, idx[7:0], lv, c};
	endtask

	// reset held five cycles; program cleared to no-ops meanwhile
	task automatic restart();
		@(posedge clock_i);
		#1 rst_i = 1'b1;
		run_i = 1'b0;
		for (int i = 0; i < 1024; i++) put(i, loc_pkg::OP_NOP, 0, 1'b0);
		repeat (5) @(posedge clock_i);
		#1 rst_i = 1'b0;
	endtask

	// one scan: runs until the end pulse, which must bring the engine back to step 0
	task automatic scan(input int lim);
		int n;
		n = 0;
		hit = '0;
		visited = '0;
		do begin
			@(posedge clock_i);
			#1 n++;
		end while (scan_end_o !== 1'b1 && n < lim);
		scan_len = n;
		`CHK(scan_end_o, 1'b1)
		`CHK(pc_o, loc_pkg::PC_RST)
	endtask

	// a generous bound: the first scan also covers the dry walk for the end step
	task automatic go();
		@(posedge clock_i);
		#1 run_i = 1'b1;
		scan(3000);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_setclr();
		restart();
		put(1, loc_pkg::OP_SET, 10, 1'b1);
		put(2, loc_pkg::OP_CLR, 10, 1'b0);
		// a timer clear is a long form, so it spans steps 3 to 5
		put(3, loc_pkg::OP_CLR, 5, 1'b1, loc_pkg::K_TMR);
		put(6, loc_pkg::OP_CLR, 7, 1'b1, loc_pkg::K_WORD);
		put(9, loc_pkg::OP_SET, 20, 1'b1, loc_pkg::K_SPEC);
		put(12, loc_pkg::OP_CLR, 6, 1'b1, loc_pkg::K_CNT);
		put(15, loc_pkg::OP_END, 0, 1'b0); // end only at the close
		go();
		`CHK(dev[10], 1'b1)
		`CHK(dev[20], 1'b1)
		`CHK(visited[7:3], 5'b01001)
		`CHK(visited[15:8], 8'h92)
		`CHK(tc_clr[5], 1'b1)
		`CHK(tc_clr[6], 1'b1)
		`CHK(tc_coil[6], 1'b0)
		`CHK(tc_coil[5], 1'b0)
		`CHK(wclr[7], 1'b1)
		prog[1].cond = 1'b0;
		scan(100);
		`CHK(dev[10], 1'b1)
		prog[2].cond = 1'b1;
		scan(100);
		`CHK(dev[10], 1'b0)
	endtask

	task automatic t_pulse();
		restart();
		put(1, loc_pkg::OP_RISE, 30, 1'b0); // one pulse per target per scan
		put(2, loc_pkg::OP_FALL, 31, 1'b1);
		put(3, loc_pkg::OP_END, 0, 1'b0);
		go();
		`CHK(hit[31:30], 2'b00)
		prog[1].cond = 1'b1;
		prog[2].cond = 1'b0;
		scan(100);
		`CHK(hit[30], 1'b1)
		`CHK(hit[31], 1'b1)
		scan(100);
		`CHK(hit[30], 1'b0)
		`CHK(dev[31:30], 2'b00)
		prog[1].cond = 1'b0;
		prog[2].cond = 1'b1;
		scan(100);
		// conditions change while stopped, so a stale history would pulse
		run_i = 1'b0;
		repeat (3) @(posedge clock_i);
		#1 prog[1].cond = 1'b1;
		prog[2].cond = 1'b0;
		run_i = 1'b1;
		scan(3000);
		`CHK(hit[31:30], 2'b00)
	endtask

	// chain written high to low, first device loaded by a set
	task automatic t_shift();
		restart();
		put(1, loc_pkg::OP_SFT, 41, 1'b0); // highest device first
		put(2, loc_pkg::OP_SFT, 40, 1'b0);
		put(3, loc_pkg::OP_BIT_SHIFT_PULSED, 51, 1'b0);
		put(4, loc_pkg::OP_SET, 39, 1'b1); // chain head loaded by a set
		put(5, loc_pkg::OP_SET, 50, 1'b1);
		put(6, loc_pkg::OP_END, 0, 1'b0);
		go();
		for (int i = 1; i < 4; i++) prog[i].cond = 1'b1;
		prog[4].cond = 1'b0;
		prog[5].cond = 1'b0;
		scan(100);
		`CHK(dev[41:39], 3'b010)
		`CHK(dev[51:50], 2'b10)
		prog[5].cond = 1'b1;
		scan(100);
		`CHK(dev[41:39], 3'b100)
		`CHK(dev[51:50], 2'b11)
	endtask

	task automatic t_mc();
		restart();
		// operands 60 and 61 appear in no other instruction
		put(1, loc_pkg::OP_MCB, 60, 1'b1);
		put(2, loc_pkg::OP_MCB, 61, 1'b1, loc_pkg::K_BIT, 3'h1);
		put(3, loc_pkg::OP_OUT, 62, 1'b1);
		put(4, loc_pkg::OP_OUT, 3, 1'b1, loc_pkg::K_TMR);
		put(5, loc_pkg::OP_OUT, 4, 1'b1, loc_pkg::K_RTMR);
		put(6, loc_pkg::OP_SET, 63, 1'b1);
		put(7, loc_pkg::OP_MCR, 0, 1'b0); // no contact right before it
		put(8, loc_pkg::OP_OUT, 64, 1'b1);
		put(9, loc_pkg::OP_END, 0, 1'b0);
		go();
		scan(100);
		len_a = scan_len;
		`CHK(dev[64:60], 5'h1F)
		`CHK(tc_coil[4:3], 2'b11)
		prog[2].cond = 1'b0;
		prog[6].cond = 1'b0;
		scan(100);
		`CHK(dev[64:60], 5'b11001)
		`CHK(tc_coil[3], 1'b0)
		`CHK(tc_clr[3], 1'b1)
		`CHK(tc_clr[4:3], 2'b01)
		`CHK(tc_coil[4], 1'b0)
		// outer level off: a gated clear must leave the latched device alone
		prog[1].cond = 1'b0;
		prog[2].cond = 1'b1;
		prog[6].op = loc_pkg::OP_CLR;
		prog[6].cond = 1'b1;
		scan(100);
		`CHK(dev[64:60], 5'b11000)
		`CHK(scan_len, len_a)
		`CHK(running_o, 1'b1)
		mon_addr_i = 8'h3F;
		repeat (2) @(posedge clock_i);
		#1 `CHK(mon_bit_o, 1'b1)
	endtask

	task automatic t_noend();
		int n;
		n = 0;
		restart();
		put(1, loc_pkg::OP_SET, 90, 1'b1);
		@(posedge clock_i);
		#1 run_i = 1'b1;
		while (op_err_o !== 1'b1 && n < 1200) begin
			@(posedge clock_i);
			#1 n++;
		end
		`CHK(op_err_o, 1'b1)
		`CHK(running_o, 1'b0)
		`CHK(dev[90], 1'b0)
		run_i = 1'b0;
		repeat (3) @(posedge clock_i);
		#1 `CHK(op_err_o, 1'b0)
	endtask

	// ----------------------------------------------------------------
	// sequence, verdict and watchdog
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		restart();
		`CHK(pc_o, loc_pkg::PC_RST)
		`CHK(running_o, 1'b0)
		t_setclr();
		t_pulse();
		t_shift();
		t_mc();
		t_noend();
		conclude();
	end

	// the whole run needs well under 20000 cycles
	initial begin
		#80000;
		err_count++;
		conclude();
	end
endmodule // tb
